/* File: rtl/host_dma_strobe_timing.sv */
// host dma strobe timing: master strobe sequencer and slave ready timer that holds ready until the strobe ends
// assumes the master core's clock is already chosen upstream and arrives as clk
`timescale 1ns/1ps
module host_dma_strobe_timing
  import dma_strobe_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        dma_timing_reg,
  input  wire logic              burst_mode,
  input  wire logic              write_mode,
  input  wire logic              buffer_core_master,
  input  wire logic              transfer_request,
  output logic                   transfer_acknowledge,
  output logic                   master_read_strobe,
  output logic                   master_write_strobe,
  input  wire logic [DATA_W-1:0] src_data,
  input  wire logic              src_valid,
  output logic                   src_ready,
  output logic [DATA_W-1:0]      host_data_out,
  output logic                   host_data_oe_n,
  input  wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0]      read_data,
  output logic                   read_valid,
  input  wire logic              slave_read_strobe,
  input  wire logic              slave_write_strobe,
  input  wire logic              slave_dual_port,
  output logic                   slave_ready
);

  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin inputs: three flops, change accepted when stages two and three agree
  localparam int unsigned NPIN = 4;
  logic [NPIN-1:0] pin_raw;                  // raw pins
  logic [NPIN-1:0] pin_s1;                   // first stage, read only by stage two
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin;                      // filtered level
  logic [NPIN-1:0] next_pin;
  assign pin_raw = {slave_dual_port, slave_write_strobe, slave_read_strobe, transfer_request};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_comb begin
        next_pin[g] = (pin_s2[g] == pin_s3[g]) ? pin_s3[g] : pin[g];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin    <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin    <= next_pin;
    end
  end

  logic          req;
  slave_access_t sacc;
  assign req  = pin[0];
  // slave pins taken from the agreeing stages directly; the extra register would cost
  // a clock that the ready window cannot spare
  assign sacc = '{read_strobe: next_pin[1], write_strobe: next_pin[2], dual_port: next_pin[3]};

  // configuration carried as one struct; the selected clock arrives on clk
  strobe_cfg_t cfg;
  assign cfg = '{delay_sel:   dma_timing_reg[DELAY_SEL_BIT],
                 low_cnt:     dma_timing_reg[LOW_CNT_LSB +: CNT_FIELD_W],
                 high_cnt:    dma_timing_reg[HIGH_CNT_LSB +: CNT_FIELD_W],
                 burst:       burst_mode,
                 write:       write_mode,
                 buffer_core: buffer_core_master};

  logic [3:0] low_clks;                      // asserted width in clocks
  logic [3:0] high_clks;                     // negated width in clocks
  logic [3:0] delay_clks;                    // ack to first strobe
  assign low_clks   = WIDTH_BASE + {1'b0, cfg.low_cnt};
  assign high_clks  = WIDTH_BASE + {1'b0, cfg.high_cnt};
  assign delay_clks = cfg.delay_sel ? DELAY_LONG : DELAY_SHORT;

  // write data waits in the fifo; the source stalls when it is full
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_pop;
  dma_word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (src_data),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // master sequencer
  typedef enum logic [2:0] {M_IDLE, M_WAIT, M_DELAY, M_LOW, M_HIGH, M_HOLD} mstate_t;
  mstate_t    mst;
  mstate_t    next_mst;
  logic [3:0] cnt;                           // clocks spent in current phase
  logic [3:0] next_cnt;
  logic [1:0] tail;                          // cycles done since request dropped
  logic [1:0] next_tail;
  logic       req_low_seen;                  // request has dropped this transfer
  logic       next_req_low_seen;
  logic       ack;
  logic       next_ack;
  logic       strobe;
  logic       next_strobe;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] next_dout;
  logic       drive;
  logic       next_drive;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic       rvalid;
  logic       next_rvalid;
  logic       more;                          // another cycle may start

  // a write cycle needs a word; request drop allows only the tail cycles
  // one cycle may already have started inside the request filter delay, so only
  // one more is begun once the drop is seen; this keeps the tail within limit
  always_comb begin
    more = (req || (req_low_seen && tail < TAIL_CYCLES - 2'h1))
           && (!cfg.write || fifo_valid);
  end

  // next state of the master sequencer
  always_comb begin
    next_mst          = mst;
    next_cnt          = cnt + 4'h1;
    next_tail         = tail;
    next_req_low_seen = req_low_seen || (ack && !req);
    next_ack          = ack;
    next_strobe       = strobe;
    next_dout         = dout;
    next_drive        = drive;
    next_rdata        = rdata;
    next_rvalid       = 1'b0;
    fifo_pop          = 1'b0;
    case (mst)
      M_IDLE: begin
        next_cnt          = 4'h0;
        next_tail         = 2'h0;
        next_req_low_seen = 1'b0;
        if (req && (!cfg.write || fifo_valid)) begin
          next_mst = M_WAIT;
          next_cnt = 4'h1;
        end
      end
      M_WAIT: begin
        // hold off the ack for the least request-to-ack wait
        if (cnt >= REQ_TO_ACK) begin
          next_mst   = M_DELAY;
          next_ack   = 1'b1;
          next_cnt   = 4'h1;
          next_drive = cfg.write;
          if (cfg.write) begin
            next_dout = fifo_data;
            fifo_pop  = 1'b1;
          end
        end
      end
      M_DELAY: begin
        if (cnt >= delay_clks) begin
          next_mst    = M_LOW;
          next_strobe = 1'b1;
          next_cnt    = 4'h1;
        end
      end
      M_LOW: begin
        if (cnt >= low_clks) begin
          next_strobe = 1'b0;
          next_cnt    = 4'h1;
          next_rdata  = host_data_in;
          next_rvalid = !cfg.write;
          if (req_low_seen || !req) begin
            next_tail = tail + 2'h1;
          end
          // burst keeps ack across cycles; single cycle drops it after each
          next_mst = cfg.burst ? M_HIGH : M_HOLD;
        end
      end
      M_HIGH: begin
        // burst: period is low plus high clocks
        if (cnt >= high_clks) begin
          if (more) begin
            next_mst    = M_LOW;
            next_strobe = 1'b1;
            next_cnt    = 4'h1;
            if (cfg.write) begin
              next_dout = fifo_data;
              fifo_pop  = 1'b1;
            end
          end else begin
            next_mst = M_HOLD;
            next_cnt = 4'h1;
          end
        end
      end
      M_HOLD: begin
        // ack outlasts the last strobe; single cycle also keeps the negated width
        if (cnt >= (cfg.burst ? ACK_HOLD : high_clks)) begin
          next_ack   = 1'b0;
          next_drive = 1'b0;
          next_mst   = M_IDLE;
        end
      end
      default: begin
        next_mst    = M_IDLE;
        next_ack    = 1'b0;
        next_strobe = 1'b0;
        next_drive  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mst          <= M_IDLE;
      cnt          <= 4'h0;
      tail         <= 2'h0;
      req_low_seen <= 1'b0;
      ack          <= 1'b0;
      strobe       <= 1'b0;
      dout         <= '0;
      drive        <= 1'b0;
      rdata        <= '0;
      rvalid       <= 1'b0;
    end else begin
      mst          <= next_mst;
      cnt          <= next_cnt;
      tail         <= next_tail;
      req_low_seen <= next_req_low_seen;
      ack          <= next_ack;
      strobe       <= next_strobe;
      dout         <= next_dout;
      drive        <= next_drive;
      rdata        <= next_rdata;
      rvalid       <= next_rvalid;
    end
  end

  assign transfer_acknowledge = ack;
  assign master_read_strobe   = strobe && !cfg.write;
  assign master_write_strobe  = strobe && cfg.write;
  assign host_data_out        = dout;
  assign host_data_oe_n       = !drive;
  assign read_data            = rdata;
  assign read_valid           = rvalid;

  // slave ready timer: counts from the filtered leading strobe edge
  typedef enum logic [1:0] {S_IDLE, S_COUNT, S_READY} sstate_t;
  sstate_t    sst;
  sstate_t    next_sst;
  logic [3:0] scnt;
  logic [3:0] next_scnt;
  logic [3:0] target;
  logic       rdy;
  logic       next_rdy;
  logic       any_strobe;
  localparam logic [3:0] SEEN_CLKS = 4'h4;   // first edge able to raise ready after the pin edge
  assign any_strobe = sacc.read_strobe || sacc.write_strobe;

  // latency chosen by target and direction; the sync delay eats part of it
  always_comb begin
    if (!sacc.dual_port) begin
      target = RDY_REG;
    end else if (sacc.read_strobe) begin
      target = RDY_DP_READ;
    end else begin
      target = RDY_DP_WRITE;
    end
  end

  always_comb begin
    next_sst  = sst;
    next_scnt = scnt;
    next_rdy  = rdy;
    case (sst)
      S_IDLE: begin
        // the filter has spent three clocks; short latencies answer on the next edge
        next_scnt = SEEN_CLKS;
        next_rdy  = 1'b0;
        if (any_strobe) begin
          if (target < SEEN_CLKS) begin
            next_sst = S_READY;
            next_rdy = 1'b1;
          end else begin
            next_sst = S_COUNT;
          end
        end
      end
      S_COUNT: begin
        next_scnt = scnt + 4'h1;
        if (scnt >= target) begin
          next_sst = S_READY;
          next_rdy = 1'b1;
        end
      end
      S_READY: begin
        // ready stays up until the strobe ends, which the other side waits for
        if (!any_strobe) begin
          next_sst = S_IDLE;
          next_rdy = 1'b0;
        end
      end
      default: begin
        next_sst = S_IDLE;
        next_rdy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sst  <= S_IDLE;
      scnt <= 4'h0;
      rdy  <= 1'b0;
    end else begin
      sst  <= next_sst;
      scnt <= next_scnt;
      rdy  <= next_rdy;
    end
  end

  assign slave_ready = rdy;
endmodule // host_dma_strobe_timing

/* File: pkg/dma_strobe_pkg.sv */
// package for the host dma strobe timing block: field layout, timing counts, carriers
// assumes one 50 MHz system clock; counts are in clock cycles
package dma_strobe_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 20;      // system clock period
  localparam int unsigned DATA_W            = 16;      // host data width
  localparam int unsigned FIFO_DEPTH        = 4;       // words buffered toward the slave

  // dma timing register layout (8 bits, loaded as a plain input)
  localparam int unsigned DELAY_SEL_BIT     = 6;       // strobe delay select
  localparam int unsigned LOW_CNT_LSB       = 0;       // strobe low count field lsb
  localparam int unsigned HIGH_CNT_LSB      = 3;       // strobe high count field lsb
  localparam int unsigned CNT_FIELD_W       = 3;       // both count fields 3 bits
  localparam logic [7:0]  DMA_TIMING_RESET  = 8'h00;   // reset value of the timing word

  // strobe timing figures in clocks
  localparam logic [3:0]  DELAY_SHORT       = 4'h2;    // ack to strobe, select = 0
  localparam logic [3:0]  DELAY_LONG        = 4'h4;    // ack to strobe, select = 1
  localparam logic [3:0]  WIDTH_BASE        = 4'h2;    // field value 0 gives 2 clocks
  localparam logic [3:0]  REQ_TO_ACK        = 4'h2;    // least wait request to ack
  localparam logic [3:0]  ACK_HOLD          = 4'h2;    // ack held after last strobe high
  localparam logic [1:0]  TAIL_CYCLES       = 2'h2;    // cycles allowed after request drops

  // slave ready latencies in clocks after the leading strobe edge
  localparam logic [3:0]  RDY_REG           = 4'h3;    // non dual-port access
  localparam logic [3:0]  RDY_DP_READ       = 4'h5;    // dual-port read
  localparam logic [3:0]  RDY_DP_WRITE      = 4'h3;    // dual-port write

  typedef struct packed {
    logic       delay_sel;                             // 1: four clock strobe delay
    logic [2:0] low_cnt;                               // asserted width minus two
    logic [2:0] high_cnt;                              // negated width minus two
    logic       burst;                                 // 1: burst, 0: single cycle
    logic       write;                                 // 1: write to slave
    logic       buffer_core;                           // 1: buffer-side core is master
  } strobe_cfg_t;

  typedef struct packed {
    logic       read_strobe;                           // slave read strobe, high active
    logic       write_strobe;                          // slave write strobe, high active
    logic       dual_port;                             // access hits the dual-port store
  } slave_access_t;

endpackage

/* File: rtl/dma_word_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
// assumes a single clock and a synchronous active-low reset copy from the top
`timescale 1ns/1ps
module dma_word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // storage words
  logic [AW-1:0]    wr_ptr;          // next slot to fill
  logic [AW-1:0]    rd_ptr;          // next slot to drain
  logic [AW:0]      fill;            // words held
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill < (AW+1)'(DEPTH));   // room left while fewer than depth words held
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and fill arithmetic, wrap at depth
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_fill = fill + 1'b1;
    end else if (pop && !push) begin
      next_fill = fill - 1'b1;
    end
  end

  // register pointers; storage written only on a push
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // dma_word_fifo

/* File: tb/dma_strobe_checker.sv */
// concurrent checks on the ports of the host dma strobe timing block
// assumes one clock and the raw active-low reset of the top module
`timescale 1ns/1ps
module dma_strobe_checker
  import dma_strobe_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] dma_timing_reg,
  input wire logic       burst_mode,
  input wire logic       transfer_request,
  input wire logic       transfer_acknowledge,
  input wire logic       master_read_strobe,
  input wire logic       master_write_strobe,
  input wire logic       slave_read_strobe,
  input wire logic       slave_write_strobe,
  input wire logic       slave_dual_port,
  input wire logic       slave_ready
);
  logic       stb;     // either master strobe
  logic       sstb;    // either slave strobe
  logic       seen;    // a strobe already ran inside this ack
  logic [3:0] hi_cnt;  // cycles the strobe has been high
  logic [4:0] lo_cnt;  // cycles the strobe has been low inside ack
  logic [3:0] s_cnt;   // cycles the slave strobe has been high
  logic [2:0] tail;    // strobes begun while request is low
  assign stb = master_read_strobe | master_write_strobe;
  assign sstb = slave_read_strobe | slave_write_strobe;
  // counters only; hi_cnt and s_cnt saturate so a stuck strobe cannot wrap into a pass, lo_cnt wraps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= 4'h0;
      lo_cnt <= 5'h00;
      s_cnt  <= 4'h0;
      seen   <= 1'b0;
      tail   <= 3'h0;
    end else begin
      hi_cnt <= stb ? ((hi_cnt == 4'hF) ? hi_cnt : hi_cnt + 4'h1) : 4'h0;
      lo_cnt <= (!transfer_acknowledge || stb) ? 5'h00 : lo_cnt + 5'h01;
      s_cnt  <= sstb ? ((s_cnt == 4'hF) ? s_cnt : s_cnt + 4'h1) : 4'h0;
      seen   <= transfer_acknowledge && (seen || stb);
      if (transfer_request) begin
        tail <= 3'h0;
      end else if ($rose(stb) && tail != 3'h7) begin
        tail <= tail + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_DELAY_SHORT: assert property ($rose(transfer_acknowledge) && !dma_timing_reg[6] |->
    !stb[*2] ##1 stb) else $error("strobe not two clocks after ack");
  AST_DELAY_LONG: assert property ($rose(transfer_acknowledge) && dma_timing_reg[6] |->
    !stb[*4] ##1 stb) else $error("strobe not four clocks after ack");
  AST_HIGH_WIDTH: assert property ($fell(stb) |-> hi_cnt == 4'h2 + {1'b0, dma_timing_reg[2:0]})
    else $error("strobe asserted width wrong");
  AST_GAP_WIDTH: assert property ($rose(stb) && seen |-> lo_cnt == 5'h02 + {2'h0, dma_timing_reg[5:3]})
    else $error("strobe negated width wrong");
  AST_REQ_TO_ACK: assert property ($rose(transfer_acknowledge) && burst_mode |->
    $past(transfer_request, 1) && $past(transfer_request, 2)) else $error("ack too soon");
  AST_ACK_HOLD: assert property ($fell(transfer_acknowledge) |-> !stb && !$past(stb, 1) && !$past(stb, 2))
    else $error("ack dropped too soon after strobe");
  AST_TAIL: assert property (!transfer_request |-> tail <= 3'h2)
    else $error("too many strobes after request dropped");
  AST_RDY_PLAIN: assert property ($rose(slave_ready) && !slave_dual_port |-> s_cnt inside {[3:4]})
    else $error("register ready latency wrong");
  AST_RDY_DP_RD: assert property ($rose(slave_ready) && slave_dual_port && slave_read_strobe |->
    s_cnt inside {[5:9]}) else $error("store read ready latency wrong");
  AST_RDY_DP_WR: assert property ($rose(slave_ready) && slave_dual_port && slave_write_strobe |->
    s_cnt inside {[3:7]}) else $error("store write ready latency wrong");
  COV_BURST: cover property ($rose(transfer_acknowledge) && burst_mode);
  COV_GAP: cover property ($rose(stb) && seen);
  COV_DP_READ: cover property ($rose(slave_ready) && slave_dual_port && slave_read_strobe);
endmodule // dma_strobe_checker

bind host_dma_strobe_timing dma_strobe_checker chk (.clk(clk), .resetn(resetn),
  .dma_timing_reg(dma_timing_reg), .burst_mode(burst_mode), .transfer_request(transfer_request),
  .transfer_acknowledge(transfer_acknowledge), .master_read_strobe(master_read_strobe),
  .master_write_strobe(master_write_strobe), .slave_read_strobe(slave_read_strobe),
  .slave_write_strobe(slave_write_strobe), .slave_dual_port(slave_dual_port),
  .slave_ready(slave_ready));

/* File: tb/dma_slave_model.sv */
// behavioural dma slave on the far side of the master strobes
// assumes the bench pulses start with a word count; data lines pulled up when idle
`timescale 1ns/1ps
module dma_slave_model
  import dma_strobe_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rd_stb,
  input  wire logic              wr_stb,
  input  wire logic              oe_n,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              start,
  input  wire logic [3:0]        words,
  output logic                   req,
  output logic [DATA_W-1:0]      rdata,
  output logic [DATA_W-1:0]      got_data,
  output logic                   got_valid
);
  logic [3:0]        left = 4'h0;   // words still wanted
  logic [7:0]        rd_idx = 8'h00; // read pattern index
  logic              rd_d = 1'b0;
  logic              wr_d = 1'b0;
  logic [DATA_W-1:0] wq;             // last value seen under the write strobe
  assign req = (left != 4'h0);
  // drive read data only under the strobe, else the pull-up level shows
  assign rdata = rd_stb ? {8'hA5, rd_idx} : 16'hFFFF;
  always_ff @(posedge clk) begin
    rd_d <= rd_stb;
    wr_d <= wr_stb;
    got_valid <= 1'b0;
    if (wr_stb) begin
      wq <= oe_n ? 16'hFFFF : wdata;
    end
    if (start) begin
      left <= words;
    end else if ((rd_d && !rd_stb) || (wr_d && !wr_stb)) begin
      // request drops with the last wanted word; extra tail cycles still accepted
      if (left != 4'h0) left <= left - 4'h1;
      if (wr_d) got_valid <= 1'b1;
      if (wr_d) got_data <= wq;
      if (rd_d) rd_idx <= rd_idx + 8'h01;
    end
  end
endmodule // dma_slave_model

/* File: tb/tb.sv */
// self-checking bench for host dma strobe timing with a dma slave model
// assumes package, fifo, top, checker and slave model compiled before it
`timescale 1ns/1ps
module tb;
  import dma_strobe_pkg::*;
  logic              clk, resetn, burst_mode, write_mode, buffer_core_master;
  logic [7:0]        dma_timing_reg;
  logic              transfer_request, transfer_acknowledge, master_read_strobe;
  logic              master_write_strobe, src_valid, src_ready, host_data_oe_n, read_valid;
  logic [DATA_W-1:0] src_data, host_data_out, host_data_in, read_data, got_data;
  logic              slave_read_strobe, slave_write_strobe, slave_dual_port, slave_ready;
  logic              start, got_valid;
  logic [3:0]        words;
  logic [15:0]       exp_q[$];        // words written, in order
  logic [31:0]       v;
  int                errors, compares, seed, rxn, r;

  host_dma_strobe_timing uut (.clk(clk), .resetn(resetn), .dma_timing_reg(dma_timing_reg),
    .burst_mode(burst_mode), .write_mode(write_mode), .buffer_core_master(buffer_core_master),
    .transfer_request(transfer_request), .transfer_acknowledge(transfer_acknowledge),
    .master_read_strobe(master_read_strobe), .master_write_strobe(master_write_strobe),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n), .host_data_in(host_data_in),
    .read_data(read_data), .read_valid(read_valid), .slave_read_strobe(slave_read_strobe),
    .slave_write_strobe(slave_write_strobe), .slave_dual_port(slave_dual_port),
    .slave_ready(slave_ready));
  dma_slave_model peer (.clk(clk), .rd_stb(master_read_strobe), .wr_stb(master_write_strobe),
    .oe_n(host_data_oe_n), .wdata(host_data_out), .start(start), .words(words),
    .req(transfer_request), .rdata(host_data_in), .got_data(got_data), .got_valid(got_valid));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    errors++;
    $display("mismatch at %0t: wait ran out", $time);
    end_of_test();
  endtask
  // valid stays up between words so no signal is driven twice in one step
  task automatic push(input logic [15:0] d);
    int i;
    src_data = d;
    src_valid = 1'b1;
    exp_q.push_back(d);
    for (i = 0; i < 40 && src_ready !== 1'b1; i++) tick();
    if (src_ready !== 1'b1) timeout();
    tick();
  endtask
  task automatic xfer(input logic [6:0] tim, input logic b, input logic w, input logic [3:0] n);
    int i;
    int r0;
    int q;
    r0 = rxn;
    dma_timing_reg = {1'b0, tim};
    burst_mode = b;
    write_mode = w;
    buffer_core_master = tim[0];
    if (w) for (i = 0; i < n; i++) push(16'($random(seed)));
    src_valid = 1'b0;
    if (w && n == 4'h4) check({15'h0, src_ready}, 16'h0000);
    words = n;
    start = 1'b1;
    tick();
    start = 1'b0;
    // done once request and ack stay low for 12 clocks; a tail cycle may still follow a gap
    q = 0;
    for (i = 0; i < 900 && q < 12; i++) begin
      tick();
      q = (transfer_request || transfer_acknowledge) ? 0 : q + 1;
    end
    if (q < 12) timeout();
    if (w) check(16'(exp_q.size()), 16'h0000);
    else check({15'h0, rxn >= r0 + int'(n)}, 16'h0001);
    $display("transfer done burst %0d write %0d words %0d", b, w, n);
  endtask
  // strobe held until ready has been sampled high, then one clock of recovery
  task automatic slave(input logic rd, input logic dp);
    int i;
    logic [3:0] lo, hi;
    lo = (dp && rd) ? 4'h5 : 4'h3;
    hi = !dp ? 4'h4 : (rd ? 4'h9 : 4'h7);
    slave_dual_port = dp;
    slave_read_strobe = rd;
    slave_write_strobe = !rd;
    for (i = 0; i < 20 && slave_ready !== 1'b1; i++) tick();
    if (slave_ready !== 1'b1) timeout();
    check({15'h0, (i - 1 >= lo) && (i - 1 <= hi)}, 16'h0001);
    tick();
    slave_read_strobe = 1'b0;
    slave_write_strobe = 1'b0;
    for (i = 0; i < 20 && slave_ready !== 1'b0; i++) tick();
    check({15'h0, slave_ready}, 16'h0000);
    tick();
    $display("slave access done read %0d store %0d", rd, dp);
  endtask
  // read words arrive in pattern order, written words in push order
  always @(posedge clk) begin
    if (read_valid === 1'b1) begin
      check(read_data, {8'hA5, 8'(rxn)});
      rxn++;
    end
    if (got_valid === 1'b1) check(got_data, exp_q.pop_front());
  end
  initial begin
    seed = 13;
    errors = 0;
    compares = 0;
    rxn = 0;
    resetn = 1'b0;
    {burst_mode, write_mode, buffer_core_master, src_valid, start} = 5'h00;
    {slave_read_strobe, slave_write_strobe, slave_dual_port} = 3'h0;
    dma_timing_reg = 8'h00;
    src_data = 16'h0000;
    words = 4'h0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) tick();
    check({15'h0, host_data_oe_n}, 16'h0001);
    xfer(7'h00, 1'b1, 1'b1, 4'h4);
    xfer(7'h7F, 1'b1, 1'b0, 4'h4);
    xfer(7'h3F, 1'b0, 1'b1, 4'h3);
    xfer(7'h40, 1'b0, 1'b0, 4'h2);
    for (r = 0; r < 12; r++) begin
      v = $random(seed);
      xfer(v[6:0], v[8], v[9], 4'({2'h0, v[11:10]} + 4'h1));
    end
    for (r = 0; r < 10; r++) begin
      v = $random(seed);
      slave(r < 4 ? r[0] : v[0], r < 4 ? r[1] : v[1]);
    end
    end_of_test();
  end
endmodule // tb
